// ### hdl/port_a_timer_pin_select.sv
/*
  Pin function selection of port A bits 2 and 3 with an AXI4-Lite
  register slave.
  Assumes pins are synchronous to aclk; the caller resolves the pad.
*/
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns

module port_a_timer_pin_select
  import pin_select_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int NUM_WIDE = 3
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // timer side
  input wire timer_drive_t timer_drive,
  output timer_sense_t timer_sense,
  // pins, index 0 is port bit 2, index 1 is port bit 3
  input wire logic [1:0] pin_in,
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe
);

  localparam int NREG = 10;
  localparam logic [7:0] OFFS [NREG] = '{`OFF_TIMER_MODE, `OFF_CH0_IO_CTRL,
    `OFF_WIDE_CTRL0, `OFF_WIDE_CTRL1, `OFF_WIDE_CTRL2, `OFF_NARROW0_CTRL,
    `OFF_NARROW2_CTRL, `OFF_PATTERN_EN, `OFF_PORT_DIR, `OFF_PORT_DATA};

  logic [7:0] regs_r [NREG];
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic wstrb0_r;
  logic aw_got_r;
  logic w_got_r;
  logic [1:0] func_a_r;
  logic [1:0] func_b_r;
  logic [1:0] pin_in_r;

  // write channel
  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire do_write = aw_got_r & w_got_r & ~s_axi_bvalid;
  wire [NREG-1:0] wr_hit;
  wire [NREG-1:0] rd_hit;
  wire wr_mapped = |wr_hit;
  wire rd_mapped = (|rd_hit) | (s_axi_araddr[7:0] == `OFF_PIN_STATUS);

  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++)
    begin : g_reg
      assign wr_hit[gi] = (awaddr_r[7:0] == OFFS[gi]);
      assign rd_hit[gi] = (s_axi_araddr[7:0] == OFFS[gi]);
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          regs_r[gi] <= `REG_RESET;
        else if (do_write && wr_hit[gi] && wstrb0_r)
          regs_r[gi] <= wdata_r[7:0];
      end
    end
  endgenerate

  // field decode
  wire pulse_mode = regs_r[0][`PULSE_MODE_POS];
  wire [2:0] io_a = regs_r[1][`IO_A_LSB +: 3];
  wire [2:0] io_b = regs_r[1][`IO_B_LSB +: 3];
  wire [2:0] narrow0_sel = regs_r[5][`CLOCK_SEL_LSB +: 3];
  wire [2:0] narrow2_sel = regs_r[6][`CLOCK_SEL_LSB +: 3];
  wire pat_en2 = regs_r[7][`PIN2_POS];
  wire pat_en3 = regs_r[7][`PIN3_POS];
  wire dir2 = regs_r[8][`PIN2_POS];
  wire dir3 = regs_r[8][`PIN3_POS];
  wire dout2 = regs_r[9][`PIN2_POS];
  wire dout3 = regs_r[9][`PIN3_POS];

  wire [NUM_WIDE-1:0] presc_c;
  wire [NUM_WIDE-1:0] presc_d;
  generate
    for (gi = 0; gi < NUM_WIDE; gi++)
    begin : g_wide
      assign presc_c[gi] = (regs_r[2+gi][`PRESCALE_LSB +: 3] == 3'h6);
      assign presc_d[gi] = (regs_r[2+gi][`PRESCALE_LSB +: 3] == 3'h7);
    end
  endgenerate

  // compare output on bit 2 when pulse mode; on either bit when io top bit 0 with low bits nonzero, bit 3 only outside pulse mode
  wire tmr_out_a = pulse_mode | (~io_a[2] & (|io_a[1:0]));
  wire tmr_out_b = ~pulse_mode & ~io_b[2] & (|io_b[1:0]);
  wire cap_a_sel = io_a[2];
  wire cap_b_sel = ~pulse_mode & io_b[2];
  wire clk_c_sel = (|presc_c) | (narrow0_sel[2:1] == 2'h3);
  wire clk_d_sel = (|presc_d) | (narrow2_sel[2:1] == 2'h3);

  wire [1:0] func_a_nxt = tmr_out_a ? FUNC_TIMER_OUT : !dir2 ? FUNC_PORT_IN :
                          pat_en2 ? FUNC_PATTERN : FUNC_PORT_OUT;
  wire [1:0] func_b_nxt = tmr_out_b ? FUNC_TIMER_OUT : !dir3 ? FUNC_PORT_IN :
                          pat_en3 ? FUNC_PATTERN : FUNC_PORT_OUT;
  wire out_a_nxt = tmr_out_a ? timer_drive.cmp_a :
                   pat_en2 ? timer_drive.pattern2 : dout2;
  wire out_b_nxt = tmr_out_b ? timer_drive.cmp_b :
                   pat_en3 ? timer_drive.pattern3 : dout3;

  // pin drive
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_out <= 2'h0;
      pin_oe <= 2'h0;
      func_a_r <= FUNC_PORT_IN;
      func_b_r <= FUNC_PORT_IN;
    end
    else
    begin
      pin_out <= {out_b_nxt, out_a_nxt};
      pin_oe <= {func_b_nxt != FUNC_PORT_IN, func_a_nxt != FUNC_PORT_IN};
      func_a_r <= func_a_nxt;
      func_b_r <= func_b_nxt;
    end
  end

  // timer inputs keep sampling whatever the pin direction
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_sense <= '0;
      pin_in_r <= 2'h0;
    end
    else
    begin
      timer_sense.capture_a <= cap_a_sel & pin_in[0];
      timer_sense.capture_b <= cap_b_sel & pin_in[1];
      timer_sense.ext_clock_c <= clk_c_sel & pin_in[0];
      timer_sense.ext_clock_d <= clk_d_sel & pin_in[1];
      pin_in_r <= pin_in;
    end
  end

  // write address and data taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0;
      wstrb0_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= ~aw_got_r & ~aw_hs & ~s_axi_bvalid;
      s_axi_wready <= ~w_got_r & ~w_hs & ~s_axi_bvalid;
      if (aw_hs)
      begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (w_hs)
      begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb0_r <= s_axi_wstrb[0];
      end
      if (do_write)
      begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read channel
  logic [31:0] rd_word;
  always_comb
  begin
    rd_word = 32'h0;
    for (int i = 0; i < NREG; i++)
      if (rd_hit[i])
        rd_word = {24'h0, regs_r[i]};
    if (s_axi_araddr[7:0] == `OFF_PIN_STATUS)
      rd_word = {24'h0, pin_in_r, pin_oe, func_b_r, func_a_r};
  end

  wire ar_hs = s_axi_arvalid & s_axi_arready;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_rvalid & ~ar_hs;
      if (ar_hs)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // checks
  chk_a_port_in: assert property (@(posedge aclk) disable iff (!aresetn)
    !tmr_out_a && !dir2 |=> !pin_oe[0] && func_a_r == FUNC_PORT_IN)
    else $error("bit 2 should be a port input");

  chk_a_port_out: assert property (@(posedge aclk) disable iff (!aresetn)
    !tmr_out_a && dir2 && !pat_en2 |=> pin_oe[0] && pin_out[0] == $past(dout2))
    else $error("bit 2 port output wrong");

  chk_a_pattern_out: assert property (@(posedge aclk) disable iff (!aresetn)
    !tmr_out_a && dir2 && pat_en2
    |=> pin_oe[0] && pin_out[0] == $past(timer_drive.pattern2))
    else $error("bit 2 pattern output wrong");

  chk_a_compare_out: assert property (@(posedge aclk) disable iff (!aresetn)
    (pulse_mode || (!io_a[2] && io_a[1:0] != 2'h0))
    |=> pin_oe[0] && pin_out[0] == $past(timer_drive.cmp_a))
    else $error("bit 2 compare output not driven");

  chk_capture_a_route: assert property (@(posedge aclk) disable iff (!aresetn)
    io_a[2] |=> timer_sense.capture_a == $past(pin_in[0]))
    else $error("capture a not routed");

  chk_clock_c_route: assert property (@(posedge aclk) disable iff (!aresetn)
    (regs_r[2][2:0] == 3'h6 || regs_r[3][2:0] == 3'h6 || regs_r[4][2:0] == 3'h6)
    |=> timer_sense.ext_clock_c == $past(pin_in[0]))
    else $error("clock c not taken from bit 2");

  chk_clock_c_narrow: assert property (@(posedge aclk) disable iff (!aresetn)
    narrow0_sel[2:1] == 2'h3 && $stable(pin_in[0]) |=> timer_sense.ext_clock_c == pin_in_r[0])
    else $error("narrow clock c not taken");

  chk_clock_c_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !clk_c_sel |=> !timer_sense.ext_clock_c)
    else $error("clock c active while unselected");

  chk_clock_d_route: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_d_sel |=> timer_sense.ext_clock_d == $past(pin_in[1]))
    else $error("clock d not taken from bit 3");

  chk_b_compare_out: assert property (@(posedge aclk) disable iff (!aresetn)
    tmr_out_b |=> pin_oe[1] && pin_out[1] == $past(timer_drive.cmp_b))
    else $error("bit 3 compare output not driven");

  chk_input_sampled: assert property (@(posedge aclk) disable iff (!aresetn)
    !pin_oe[0] && cap_a_sel && $past(cap_a_sel)
    |-> timer_sense.capture_a == $past(pin_in[0]))
    else $error("input pin not sampled for capture");

  chk_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");

endmodule

// ### include/pin_select_defs.svh
/*
  Register offsets, field positions and reset values of the port A
  timer pin selection block.
  Assumes inclusion by bare name from the package.
*/
`ifndef PIN_SELECT_DEFS_SVH
`define PIN_SELECT_DEFS_SVH

`define OFF_TIMER_MODE 8'h00
`define OFF_CH0_IO_CTRL 8'h04
`define OFF_WIDE_CTRL0 8'h08
`define OFF_WIDE_CTRL1 8'h0C
`define OFF_WIDE_CTRL2 8'h10
`define OFF_NARROW0_CTRL 8'h14
`define OFF_NARROW2_CTRL 8'h18
`define OFF_PATTERN_EN 8'h1C
`define OFF_PORT_DIR 8'h20
`define OFF_PORT_DATA 8'h24
`define OFF_PIN_STATUS 8'h28

`define PULSE_MODE_POS 0
`define IO_A_LSB 0
`define IO_B_LSB 4
`define PRESCALE_LSB 0
`define CLOCK_SEL_LSB 0
`define PIN2_POS 2
`define PIN3_POS 3
`define REG_RESET 8'h00

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### include/pin_select_pkg.sv
/*
  Types of the port A timer pin selection block.
  Assumes pin_select_defs.svh on the include path.
*/
`include "pin_select_defs.svh"

package pin_select_pkg;

  // signals the timers and pattern unit offer for the two pins
  typedef struct packed {
    logic cmp_a;
    logic cmp_b;
    logic pattern2;
    logic pattern3;
  } timer_drive_t;

  // inputs handed on to the timers
  typedef struct packed {
    logic capture_a;
    logic capture_b;
    logic ext_clock_c;
    logic ext_clock_d;
  } timer_sense_t;

  typedef enum logic [1:0] {
    FUNC_PORT_IN,
    FUNC_PORT_OUT,
    FUNC_PATTERN,
    FUNC_TIMER_OUT
  } pin_func_t;

endpackage

// ### tb/board_pin_model.sv
/*
  Board side of the two port A pins.
  Assumes the testbench picks the level the board drives.
*/
`timescale 1ns/1ns

module board_pin_model
(
  // pad control from the block
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  // level the board drives
  input wire logic [1:0] ext_level,
  output logic [1:0] pin_in
);
  // block drive wins, else board level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// ### tb/test_port_a_timer_pin_select.sv
/*
  Self-checking bench of the port A timer pin selection block.
  Assumes the package and defines header on the include path.
*/
`timescale 1ns/1ns
`include "pin_select_defs.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end

module test_port_a_timer_pin_select
  import pin_select_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  timer_drive_t td = '0;
  timer_sense_t ts;
  logic [1:0] ext = 2'h0;
  logic [1:0] pin_in, pin_out, pin_oe;
  int errors = 0;
  int checks = 0;
  int seed = 32'h07cf;
  logic [7:0] cfg [10];

  always #2 aclk = ~aclk;

  port_a_timer_pin_select DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timer_drive(td), .timer_sense(ts), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

  board_pin_model board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));

  task end_of_test;
    if (errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40 && !(bvalid && bready); n++)
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    if (n == 40)
    begin
      errors++;
      end_of_test();
    end
    resp = bresp;
    bready <= 1'b0;
  endtask

  task axi_read(input logic [7:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40 && !(rvalid && rready); n++)
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    if (n == 40)
    begin
      errors++;
      end_of_test();
    end
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  function automatic logic [1:0] func_of(input logic cmp, input logic dir, input logic pe);
    return cmp ? 2'h3 : dir ? (pe ? 2'h2 : 2'h1) : 2'h0;
  endfunction

  // drive random timer levels and board levels, compare pads and sense
  task check_pins;
    logic pm, ca, cb, cc, cd, o2, o3;
    logic [1:0] f2, f3, oe, p, cap;
    int j;
    for (j = 0; j < 2; j++)
    begin
      @(posedge aclk);
      td <= timer_drive_t'(4'($random(seed)));
      ext <= 2'($random(seed));
      repeat (4) @(posedge aclk);
      pm = cfg[0][0];
      ca = pm || (!cfg[1][2] && cfg[1][1:0] != 2'h0);
      cb = !pm && !cfg[1][6] && cfg[1][5:4] != 2'h0;
      cc = cfg[2][2:0] == 3'h6 || cfg[3][2:0] == 3'h6 || cfg[4][2:0] == 3'h6;
      cc = cc || cfg[5][2:1] == 2'h3;
      cd = cfg[2][2:0] == 3'h7 || cfg[3][2:0] == 3'h7 || cfg[4][2:0] == 3'h7;
      cd = cd || cfg[6][2:1] == 2'h3;
      f2 = func_of(ca, cfg[8][2], cfg[7][2]);
      f3 = func_of(cb, cfg[8][3], cfg[7][3]);
      oe = {f3 != 2'h0, f2 != 2'h0};
      o2 = ca ? td.cmp_a : cfg[7][2] ? td.pattern2 : cfg[9][2];
      o3 = cb ? td.cmp_b : cfg[7][3] ? td.pattern3 : cfg[9][3];
      p = {oe[1] ? o3 : ext[1], oe[0] ? o2 : ext[0]};
      `CHK("pin_oe", oe, pin_oe)
      `CHK("pin_out", {o3, o2} & oe, pin_out & oe)
      cap = {cfg[1][2] & p[0], cfg[1][6] & !pm & p[1]};
      `CHK("capture", cap, {ts.capture_a, ts.capture_b})
      `CHK("clock c", cc & p[0], ts.ext_clock_c)
      `CHK("clock d", cd & p[1], ts.ext_clock_d)
      axi_read(`OFF_PIN_STATUS);
      `CHK("func bit2", f2, rd[1:0])
      `CHK("func bit3", f3, rd[3:2])
      `CHK("status pins", {p, oe}, rd[7:4])
    end
  endtask

  initial
  begin
    int i, k;
    logic [7:0] v;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    `CHK("oe in reset", 2'h0, pin_oe)
    axi_read(8'h2C);
    `CHK("unmapped read", {`RESP_SLVERR, 32'h0}, {resp, rd})
    axi_write(8'h30, 32'hFF);
    `CHK("unmapped write", `RESP_SLVERR, resp)
    for (i = 0; i < 60; i++)
    begin
      for (k = 0; k < 10; k++)
      begin
        v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
        cfg[k] = v;
        axi_write(8'(4 * k), {24'hFFFFFF, v});
        `CHK("write resp", `RESP_OKAY, resp)
      end
      for (k = 0; k < 10; k++)
      begin
        axi_read(8'(4 * k));
        `CHK("readback", {`RESP_OKAY, 24'h0, cfg[k]}, {resp, rd})
      end
      check_pins();
    end
    end_of_test();
  end
endmodule
